/* File: src/bcps_defs.svh */
`ifndef BCPS_DEFS_SVH
`define BCPS_DEFS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define BCPS_OFS_CS_ENABLES 12'h000
`define BCPS_OFS_CS_PIN_SEL 12'h004
`define BCPS_OFS_STROBE_CTRL 12'h008

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BCPS_CS7_SEL_HI 7
`define BCPS_CS7_SEL_LO 6
`define BCPS_CS6_SEL_HI 5
`define BCPS_CS6_SEL_LO 4
`define BCPS_CS5_SEL_HI 3
`define BCPS_CS5_SEL_LO 2
`define BCPS_CS2_SEL 6
`define BCPS_BUS_STROBE_SEL 5
`define BCPS_BUS_STROBE_OE 4
`define BCPS_RW_OE 2
`define BCPS_ADDR_STROBE_OE 1

// ------------------------------------------------------------
// writable masks and reset values
// ------------------------------------------------------------
`define BCPS_PIN_SEL_MASK 8'hfc
`define BCPS_STROBE_CTRL_MASK 8'h76
`define BCPS_CS_ENABLES_RST 8'h00
`define BCPS_PIN_SEL_RST 8'h00
`define BCPS_STROBE_CTRL_RST 8'h02

`endif

/* File: src/bcps_pkg.sv */
package bcps_pkg;
    // two-bit pin route for chip selects 7, 6 and 5
    typedef enum logic [1:0] {
        BCPS_ROUTE_A = 2'b00,
        BCPS_ROUTE_B = 2'b01,
        BCPS_ROUTE_BAD2 = 2'b10,
        BCPS_ROUTE_BAD3 = 2'b11
    } bcps_route_t;
    typedef logic [7:0] bcps_reg_t;
endpackage

/* File: src/bcps_cfg_if.sv */
interface bcps_cfg_if;
    import bcps_pkg::*;
    bcps_reg_t cs_enables;
    bcps_reg_t cs_pin_sel;
    bcps_reg_t strobe_ctrl;
    modport regs (output cs_enables, output cs_pin_sel, output strobe_ctrl);
    modport mux (input cs_enables, input cs_pin_sel, input strobe_ctrl);
endinterface

/* File: src/bcps_regs.sv */
`include "bcps_defs.svh"

module bcps_regs
    import bcps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ext_mode,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    bcps_cfg_if.regs cfg
);
    logic rst_seen;
    wire wr_en = psel && penable && pwrite;
    wire hit_en = paddr == `BCPS_OFS_CS_ENABLES;
    wire hit_sel = paddr == `BCPS_OFS_CS_PIN_SEL;
    wire hit_strobe = paddr == `BCPS_OFS_STROBE_CTRL;
    wire mapped = hit_en || hit_sel || hit_strobe;
    wire [7:0] rd_byte = hit_en ? cfg.cs_enables : hit_sel ? cfg.cs_pin_sel :
                         hit_strobe ? cfg.strobe_ctrl : 8'h00;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = {24'h0000_00, rd_byte};

    // chip select 0 enable follows the mode strap, caught on the first clock after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_seen <= 1'b0;
        end else begin
            rst_seen <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.cs_enables <= `BCPS_CS_ENABLES_RST;
        end else if (!rst_seen) begin
            cfg.cs_enables <= {7'h00, ext_mode};
        end else if (wr_en && hit_en) begin
            cfg.cs_enables <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.cs_pin_sel <= `BCPS_PIN_SEL_RST;
        end else if (wr_en && hit_sel) begin
            cfg.cs_pin_sel <= pwdata[7:0] & `BCPS_PIN_SEL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.strobe_ctrl <= `BCPS_STROBE_CTRL_RST;
        end else if (wr_en && hit_strobe) begin
            cfg.strobe_ctrl <= pwdata[7:0] & `BCPS_STROBE_CTRL_MASK;
        end
    end
endmodule

/* File: src/bcps_top.sv */
// How it works
// - enable bit gives pin to chip select
// - cs0 enable resets to external-mode strap
// - cs7 route 00 port_b_bit3, 01 port_b_bit1
// - cs6 route 00 port_b_bit2, 01 port_b_bit1
// - cs5 route 00 port_b_bit1, 01 port_b_bit0
// - routing only acts while enabled
// - shared pin carries every routed select
// - cs2 select 0 bit2, 1 bit1
// - bus strobe on bit0 or bit6
// - bus strobe enable gates its output
// - rw direction enable gates its output
// - sdram byte control forces rw output
// - address strobe enable claims port_a_bit6
// - reserved bits read zero
`include "bcps_defs.svh"

module bcps_top
    import bcps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ext_mode,
    input wire logic sdram_byte_ctrl,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] chip_select_line_n,
    input wire logic bus_strobe_n,
    input wire logic address_strobe_n,
    input wire logic rw_direction,
    output logic [7:0] cs_pin_claim,
    output logic [3:0] port_b_func_en,
    output logic [3:0] port_b_func_out,
    output logic port_a_bit0_func_en,
    output logic port_a_bit0_func_out,
    output logic port_a_bit6_func_en,
    output logic port_a_bit6_func_out,
    output logic rw_pin_func_en,
    output logic rw_pin_func_out
);
    bcps_cfg_if cfg ();

    bcps_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .ext_mode(ext_mode),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .cfg(cfg.regs)
    );

    bcps_mux u_mux (
        .pclk(pclk),
        .presetn(presetn),
        .sdram_byte_ctrl(sdram_byte_ctrl),
        .chip_select_line_n(chip_select_line_n),
        .bus_strobe_n(bus_strobe_n),
        .address_strobe_n(address_strobe_n),
        .rw_direction(rw_direction),
        .cs_pin_claim(cs_pin_claim),
        .port_b_func_en(port_b_func_en),
        .port_b_func_out(port_b_func_out),
        .port_a_bit0_func_en(port_a_bit0_func_en),
        .port_a_bit0_func_out(port_a_bit0_func_out),
        .port_a_bit6_func_en(port_a_bit6_func_en),
        .port_a_bit6_func_out(port_a_bit6_func_out),
        .rw_pin_func_en(rw_pin_func_en),
        .rw_pin_func_out(rw_pin_func_out),
        .cfg(cfg.mux)
    );
endmodule

/* File: src/bcps_mux.sv */
`include "bcps_defs.svh"

module bcps_mux
    import bcps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sdram_byte_ctrl,
    input wire logic [7:0] chip_select_line_n,
    input wire logic bus_strobe_n,
    input wire logic address_strobe_n,
    input wire logic rw_direction,
    output logic [7:0] cs_pin_claim,
    output logic [3:0] port_b_func_en,
    output logic [3:0] port_b_func_out,
    output logic port_a_bit0_func_en,
    output logic port_a_bit0_func_out,
    output logic port_a_bit6_func_en,
    output logic port_a_bit6_func_out,
    output logic rw_pin_func_en,
    output logic rw_pin_func_out,
    bcps_cfg_if.mux cfg
);
    // ------------------------------------------------------------
    // routing decode
    // ------------------------------------------------------------
    // one-hot port_b pin for a two-way route; map[cs] below holds the pins of chip select cs
    function automatic logic [3:0] route2(input logic [1:0] sel, input logic [1:0] pa,
                                          input logic [1:0] pb);
        logic [3:0] r;
        r = 4'h0;
        if (sel == BCPS_ROUTE_A) begin
            r[pa] = 1'b1;
        end else if (sel == BCPS_ROUTE_B) begin
            r[pb] = 1'b1;
        end
        return r; // prohibited codes route nowhere
    endfunction

    wire [7:0] en = cfg.cs_enables;
    wire [7:0] psel_r = cfg.cs_pin_sel;
    wire [7:0] strb = cfg.strobe_ctrl;
    wire [3:0] r7 = route2(psel_r[`BCPS_CS7_SEL_HI:`BCPS_CS7_SEL_LO], 2'd3, 2'd1);
    wire [3:0] r6 = route2(psel_r[`BCPS_CS6_SEL_HI:`BCPS_CS6_SEL_LO], 2'd2, 2'd1);
    wire [3:0] r5 = route2(psel_r[`BCPS_CS5_SEL_HI:`BCPS_CS5_SEL_LO], 2'd1, 2'd0);
    wire [3:0] r2 = strb[`BCPS_CS2_SEL] ? 4'b0010 : 4'b0100;
    // remaining selects are fixed: cs4, cs0 on bit0, cs3 bit3, cs1 bit1 (board choice)
    wire [3:0] rfix4 = 4'b0001;
    wire [3:0] rfix3 = 4'b1000;
    wire [3:0] rfix1 = 4'b0010;
    wire [3:0] rfix0 = 4'b0001;
    wire [3:0] map [8];
    assign map[7] = r7 & {4{en[7]}};
    assign map[6] = r6 & {4{en[6]}};
    assign map[5] = r5 & {4{en[5]}};
    assign map[4] = rfix4 & {4{en[4]}};
    assign map[3] = rfix3 & {4{en[3]}};
    assign map[2] = r2 & {4{en[2]}};
    assign map[1] = rfix1 & {4{en[1]}};
    assign map[0] = rfix0 & {4{en[0]}};

    logic [3:0] next_b_en;
    logic [3:0] next_b_out;
    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_pin
            wire [7:0] hits;
            for (genvar c = 0; c < 8; c++) begin : g_cs
                assign hits[c] = map[c][p];
            end
            assign next_b_en[p] = |hits;
            assign next_b_out[p] = &(chip_select_line_n | ~hits);
        end
    endgenerate

    // ------------------------------------------------------------
    // strobes
    // ------------------------------------------------------------
    wire bus_strobe_on = strb[`BCPS_BUS_STROBE_OE];
    wire bus_strobe_alt = strb[`BCPS_BUS_STROBE_SEL];
    wire addr_strobe_on = strb[`BCPS_ADDR_STROBE_OE];
    wire next_a0_en = bus_strobe_on && !bus_strobe_alt;
    // bus strobe on port_a_bit6 takes precedence over address strobe there
    wire next_a6_en = (bus_strobe_on && bus_strobe_alt) || addr_strobe_on;
    wire next_a6_out = (bus_strobe_on && bus_strobe_alt) ? bus_strobe_n : address_strobe_n;
    wire next_rw_en = strb[`BCPS_RW_OE] || sdram_byte_ctrl;

    // registered outputs keep glitches off the pads; settings act one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_pin_claim <= 8'h00;
            port_b_func_en <= 4'h0;
            port_b_func_out <= 4'hf;
            port_a_bit0_func_en <= 1'b0;
            port_a_bit0_func_out <= 1'b1;
            port_a_bit6_func_en <= 1'b0;
            port_a_bit6_func_out <= 1'b1;
            rw_pin_func_en <= 1'b0;
            rw_pin_func_out <= 1'b0;
        end else begin
            cs_pin_claim <= en;
            port_b_func_en <= next_b_en;
            port_b_func_out <= next_b_out;
            port_a_bit0_func_en <= next_a0_en;
            port_a_bit0_func_out <= bus_strobe_n;
            port_a_bit6_func_en <= next_a6_en;
            port_a_bit6_func_out <= next_a6_out;
            rw_pin_func_en <= next_rw_en;
            rw_pin_func_out <= rw_direction;
        end
    end
endmodule

/* File: tb/bcps_ext_dev.sv */
module bcps_ext_dev (
    input wire logic [3:0] func_en,
    input wire logic [3:0] func_out,
    output logic [3:0] pin_level
);
    // pins carry pull-ups, so a pin left as port reads high
    assign pin_level = ~func_en | func_out;
endmodule

/* File: tb/bcps_top_sva.sv */
module bcps_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sdram_byte_ctrl,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [7:0] chip_select_line_n,
    input wire logic bus_strobe_n,
    input wire logic [3:0] port_b_func_en,
    input wire logic [3:0] port_b_func_out,
    input wire logic port_a_bit0_func_en,
    input wire logic port_a_bit0_func_out,
    input wire logic rw_pin_func_en
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rw_forced: assert property (sdram_byte_ctrl |=> rw_pin_func_en)
        else $error("rw pin not forced");
    a_pb_idle: assert property ((port_b_func_out | port_b_func_en) == 4'hf)
        else $error("idle pin low");
    a_pb0_and: assert property (!port_b_func_out[0] |->
        ($past(chip_select_line_n) & 8'h31) != 8'h31) else $error("pin b0 low without select");
    a_pb3_and: assert property (!port_b_func_out[3] |->
        ($past(chip_select_line_n) & 8'h88) != 8'h88) else $error("pin b3 low without select");
    a_bs_level: assert property (port_a_bit0_func_en |->
        port_a_bit0_func_out == $past(bus_strobe_n)) else $error("strobe level wrong");
    a_map_ok: assert property (psel && penable && (paddr == 12'h000 ||
        paddr == 12'h004 || paddr == 12'h008) |-> !pslverr) else $error("mapped access refused");
    a_rsv_sel: assert property (psel && penable && paddr == 12'h004 |->
        prdata[1:0] == 2'b00) else $error("reserved select bits set");
    a_rsv_ctrl: assert property (psel && penable && paddr == 12'h008 |->
        {prdata[7], prdata[3], prdata[0]} == 3'b000) else $error("reserved ctrl bits set");
endmodule
bind bcps_top bcps_chk u_chk (.*);

/* File: tb/bcps_top_bench.sv */
`define CHK(nm, e, s) begin \
    n_compared++; \
    if ((s) !== (e)) begin \
        n_errors++; \
        $display("BAD %s exp %h got %h", nm, (e), (s)); \
    end \
end
module bcps_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int due; logic [43:0] kv;} bcps_note_t;
    logic pclk = 0, presetn = 0, ext_mode = 1, sdram_byte_ctrl = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic bus_strobe_n = 1, address_strobe_n = 1, rw_direction = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, seed = 48;
    logic [7:0] chip_select_line_n = 8'hff, cs_pin_claim, r_en, r_ps, r_ct;
    logic [3:0] port_b_func_en, port_b_func_out, pb_pin;
    logic port_a_bit0_func_en, port_a_bit0_func_out, port_a_bit6_func_en;
    logic port_a_bit6_func_out, rw_pin_func_en, rw_pin_func_out;
    int n_errors = 0, n_compared = 0, ncyc = 0;
    bcps_note_t q[$];
    wire [21:0] got = {cs_pin_claim, port_b_func_en, pb_pin, port_a_bit0_func_en,
        port_a_bit0_func_out, port_a_bit6_func_en, port_a_bit6_func_out, rw_pin_func_en,
        rw_pin_func_out};
    bcps_top dut (.*);
    bcps_ext_dev far (.func_en(port_b_func_en), .func_out(port_b_func_out), .pin_level(pb_pin));
    always #12.5 pclk = ~pclk;
    task automatic complete_run();
        $display("checks %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // upper half of the note masks strobe levels that are don't-care while unrouted
    function automatic logic [43:0] expv(logic [7:0] c, logic b, a, w, s);
        logic [7:0] m [4];
        logic [3:0] e, o;
        logic a0, bb, a6;
        m[0] = {2'b00, r_ps[3:2] == 2'b01, 5'h11};
        m[1] = {r_ps[7:6] == 2'b01, r_ps[5:4] == 2'b01, r_ps[3:2] == 2'b00, 2'b00, r_ct[6], 2'b10};
        m[2] = {1'b0, r_ps[5:4] == 2'b00, 3'b000, !r_ct[6], 2'b00};
        m[3] = {r_ps[7:6] == 2'b00, 7'h08};
        for (int p = 0; p < 4; p++) begin
            e[p] = |(m[p] & r_en);
            o[p] = &(c | ~(m[p] & r_en));
        end
        a0 = r_ct[4] && !r_ct[5];
        bb = r_ct[4] && r_ct[5];
        a6 = bb || r_ct[1];
        return {16'hffff, 1'b1, a0, 1'b1, a6, 2'b11, r_en, e, o, a0, b, a6, bb ? b : a,
            r_ct[2] || s, w};
    endfunction
    always @(negedge pclk) begin
        ncyc++;
        if (q.size() > 0 && q[0].due == ncyc) begin
            `CHK("pins", q[0].kv[21:0] & q[0].kv[43:22], got & q[0].kv[43:22])
            void'(q.pop_front());
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, e);
        int i;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin
            n_errors++;
            complete_run();
        end
        `CHK("slverr", a > 12'h008, pslverr)
        if (!w) `CHK("rdata", {24'h00_0000, e}, prdata)
        psel <= 0;
        penable <= 0;
    endtask
    task automatic step(input logic [31:0] r);
        @(posedge pclk);
        chip_select_line_n <= r[7:0];
        bus_strobe_n <= r[8];
        address_strobe_n <= r[9];
        rw_direction <= r[10];
        sdram_byte_ctrl <= r[11];
        q.push_back('{ncyc + 2, expv(r[7:0], r[8], r[9], r[10], r[11])});
    endtask
    initial begin
        logic [31:0] r;
        repeat (16) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h000, 0, 8'h01);
        apb(0, 12'h008, 0, 8'h02);
        apb(1, 12'h004, 8'h57, 0);
        apb(0, 12'h004, 0, 8'h54);
        apb(1, 12'h008, 8'hff, 0);
        apb(0, 12'h008, 0, 8'h76);
        apb(1, 12'h00c, 8'hff, 0);
        apb(0, 12'h00c, 0, 8'h00);
        for (int k = 0; k < 40; k++) begin
            r = rnd();
            // software never writes the prohibited route codes
            apb(1, 12'h000, r[7:0], 0);
            apb(1, 12'h004, r[15:8] & 8'h54, 0);
            apb(1, 12'h008, r[23:16] & 8'h76, 0);
            r_en = r[7:0];
            r_ps = r[15:8] & 8'h54;
            r_ct = r[23:16] & 8'h76;
            repeat (6) step(rnd());
        end
        repeat (3) @(posedge pclk);
        // second reset outside external extended mode leaves cs0 unclaimed
        presetn <= 0;
        ext_mode <= 0;
        repeat (4) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h000, 0, 8'h00);
        apb(0, 12'h008, 0, 8'h02);
        r_en = 8'h00;
        r_ps = 8'h00;
        r_ct = 8'h02;
        repeat (4) step(rnd());
        repeat (3) @(posedge pclk);
        `CHK("queue", 0, q.size())
        complete_run();
    end
endmodule
